/* rtl/rfe_tx_encoder.sv */
// Operation
// - Serialise payload bytes in selected line format
// - Three config bits pick seven formats
// - Baud bits set Manchester/MarkSpace rate
// - Baud bits set PWM rate
// - Frequency word 0 sets ASK carrier
// - FSK data picks word 0 or 1
// - Band bit selects N of 26 or 36
// - Modulator stream follows serial data level in FSK, held low in ASK
// - ASK amplifier keys with serial data
// - FSK amplifier on after PLL settled
// - Lock loss mutes amplifier, raises alarm
// - Crystal select between 24 and 26 MHz
// - Controller reads RAM bytes without CPU
// - Controller powers PLL, oscillator, encoder
// - Serial stream also on pin 2
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module rfe_tx_encoder (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Payload RAM port
    output logic      [7:0]  ram_addr,
    output logic             ram_rd,
    input  wire logic [7:0]  ram_rdata,
    // PLL and amplifier
    input  wire logic        pll_lock,
    output logic             pll_en,
    output logic             xtal_en,
    output logic             xtal_26m_sel,
    output logic      [7:0]  pll_n,
    output logic      [12:0] pll_frac,
    output logic             sd_data,
    output logic             pa_en,
    output logic             lock_alarm,
    // CPU and pin
    output logic             cpu_halt,
    output logic             gpio2_data,
    output logic             gpio2_oe_n
);
    import rfe_pkg::*;

    // ---------------------------------------------
    // Registers
    // ---------------------------------------------
    logic [7:0] cfg_q, cfg_d, f0l_q, f0l_d, f0h_q, f0h_d;
    logic [7:0] f1l_q, f1l_d, f1h_q, f1h_d, rfc_q, rfc_d;
    logic [7:0] len_q, len_d;
    logic       alarm_q, alarm_d;
    rfe_state_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d, ptr_q, ptr_d, byte_q, byte_d;
    logic [2:0] bit_q, bit_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] div_q, div_d, div_max;
    logic       ser_q, ser_d, lvl_q, lvl_d, enc_q, enc_d;
    logic       lk1_q, lk2_q;
    logic       wr, rd, go, tick, fsk, cur_bit, last_ph;
    rfe_fmt_t   fmt;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign go = wr && (paddr == RFE_ADDR_TX_CTRL) && pwdata[RFE_GO_BIT] && st_q == RFE_ST_IDLE;
    assign fmt = rfe_fmt_t'(cfg_q[2:0]);
    assign fsk = rfc_q[RFE_FSK_BIT];
    assign cur_bit = byte_q[3'd7 - bit_q];
    assign pready = 1'b1;

    // ---------------------------------------------
    // Lock synchroniser
    // ---------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk1_q <= 1'b0;
            lk2_q <= 1'b0;
        end else begin
            lk1_q <= pll_lock;
            lk2_q <= lk1_q;
        end
    end

    // ---------------------------------------------
    // Baud divider
    // ---------------------------------------------
    always_comb begin
        div_max = RFE_DIV_MS_00;
        if (fmt == RFE_FMT_PWM) begin
            case (cfg_q[RFE_BAUD_LSB+:2])
                2'b00:   div_max = RFE_DIV_PW_00;
                2'b01:   div_max = RFE_DIV_PW_01;
                2'b10:   div_max = RFE_DIV_PW_10;
                default: div_max = RFE_DIV_PW_11;
            endcase
        end else begin
            case (cfg_q[RFE_BAUD_LSB+:2])
                2'b00:   div_max = RFE_DIV_MS_00;
                2'b01:   div_max = RFE_DIV_MS_01;
                2'b10:   div_max = RFE_DIV_MS_10;
                default: div_max = RFE_DIV_MS_11;
            endcase
        end
        tick = (st_q == RFE_ST_SHIFT) && (div_q == div_max - 4'h1);
        div_d = (st_q != RFE_ST_SHIFT || tick) ? 4'h0 : div_q + 4'h1;
    end

    // ---------------------------------------------
    // Encoder and sequencer
    // ---------------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ptr_d = ptr_q;
        byte_d = byte_q;
        bit_d = bit_q;
        ph_d = ph_q;
        ser_d = ser_q;
        lvl_d = lvl_q;
        enc_d = enc_q;
        alarm_d = alarm_q;
        // Sticky alarm, write one clears, a set below wins
        if (wr && paddr == RFE_ADDR_TX_STAT && pwdata[0]) begin
            alarm_d = 1'b0;
        end
        last_ph = (fmt == RFE_FMT_PWM) ? (ph_q == 2'd2) : (ph_q == 2'd1);
        case (st_q)
            RFE_ST_IDLE: begin
                if (go) begin
                    st_d = RFE_ST_SETTLE;
                    cnt_d = RFE_SETTLE_CNT;
                    ptr_d = RFE_RAM_BASE;
                    lvl_d = 1'b0;
                end
            end
            RFE_ST_SETTLE: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (lk2_q) begin
                    st_d = RFE_ST_FETCH;
                    enc_d = 1'b1;
                end
            end
            RFE_ST_FETCH: begin
                st_d = RFE_ST_LOAD;
            end
            RFE_ST_LOAD: begin
                byte_d = ram_rdata;
                ptr_d = ptr_q + 8'h01;
                bit_d = 3'd0;
                ph_d = 2'd0;
                st_d = RFE_ST_SHIFT;
            end
            RFE_ST_SHIFT: begin
                if (tick) begin
                    ph_d = last_ph ? 2'd0 : ph_q + 2'd1;
                    if (last_ph) begin
                        bit_d = bit_q + 3'd1;
                        if (bit_q == 3'd7) begin
                            st_d = (ptr_q == RFE_RAM_BASE + len_q) ? RFE_ST_DONE : RFE_ST_FETCH;
                        end
                    end
                end
                case (fmt)
                    RFE_FMT_MARKSPACE: ser_d = cur_bit;
                    RFE_FMT_MANCH:     ser_d = cur_bit ^ ph_q[0];
                    RFE_FMT_PWM:       ser_d = (ph_q == 2'd0) || (ph_q == 2'd1 && cur_bit);
                    RFE_FMT_BIPH0:     ser_d = lvl_q ^ (ph_q[0] & ~cur_bit);
                    RFE_FMT_BIPH1:     ser_d = lvl_q ^ (ph_q[0] & cur_bit);
                    RFE_FMT_DBIPH0, RFE_FMT_DBIPH1: ser_d = lvl_q ^ ph_q[0];
                    default:           ser_d = cur_bit;
                endcase
                if (tick && last_ph) begin
                    case (fmt)
                        RFE_FMT_BIPH0:  lvl_d = ~(lvl_q ^ ~cur_bit);
                        RFE_FMT_BIPH1:  lvl_d = ~(lvl_q ^ cur_bit);
                        RFE_FMT_DBIPH0: lvl_d = lvl_q ^ cur_bit;
                        RFE_FMT_DBIPH1: lvl_d = lvl_q ^ ~cur_bit;
                        default:        lvl_d = lvl_q;
                    endcase
                end
                if (!lk2_q) begin
                    alarm_d = 1'b1;
                    enc_d = 1'b0;
                    st_d = RFE_ST_DONE;
                end
            end
            default: begin
                st_d = RFE_ST_IDLE;
                enc_d = 1'b0;
                ser_d = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------
    // Register writes
    // ---------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        f0l_d = f0l_q;
        f0h_d = f0h_q;
        f1l_d = f1l_q;
        f1h_d = f1h_q;
        rfc_d = rfc_q;
        len_d = len_q;
        if (wr) begin
            if (paddr == RFE_ADDR_BAUD_CFG) begin
                cfg_d = pwdata[7:0];
            end else if (paddr == RFE_ADDR_F0_LOW) begin
                f0l_d = pwdata[7:0];
            end else if (paddr == RFE_ADDR_F0_HIGH) begin
                f0h_d = pwdata[7:0];
            end else if (paddr == RFE_ADDR_F1_LOW) begin
                f1l_d = pwdata[7:0];
            end else if (paddr == RFE_ADDR_F1_HIGH) begin
                f1h_d = pwdata[7:0];
            end else if (paddr == RFE_ADDR_RF_CTRL) begin
                rfc_d = pwdata[7:0];
            end else if (paddr == RFE_ADDR_TX_CTRL && st_q == RFE_ST_IDLE) begin
                len_d = pwdata[15:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= RFE_RST_REG;
            f0l_q <= RFE_RST_REG;
            f0h_q <= RFE_RST_REG;
            f1l_q <= RFE_RST_REG;
            f1h_q <= RFE_RST_REG;
            rfc_q <= RFE_RST_REG;
            len_q <= RFE_LEN_RST;
            alarm_q <= 1'b0;
            st_q <= RFE_ST_IDLE;
            cnt_q <= 8'h00;
            ptr_q <= RFE_RAM_BASE;
            byte_q <= 8'h00;
            bit_q <= 3'd0;
            ph_q <= 2'd0;
            div_q <= 4'h0;
            ser_q <= 1'b0;
            lvl_q <= 1'b0;
            enc_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            f0l_q <= f0l_d;
            f0h_q <= f0h_d;
            f1l_q <= f1l_d;
            f1h_q <= f1h_d;
            rfc_q <= rfc_d;
            len_q <= len_d;
            alarm_q <= alarm_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            byte_q <= byte_d;
            bit_q <= bit_d;
            ph_q <= ph_d;
            div_q <= div_d;
            ser_q <= ser_d;
            lvl_q <= lvl_d;
            enc_q <= enc_d;
        end
    end

    // ---------------------------------------------
    // Read mux and outputs
    // ---------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (rd) begin
            if (paddr == RFE_ADDR_BAUD_CFG) begin
                prdata[7:0] = cfg_q;
            end else if (paddr == RFE_ADDR_F0_LOW) begin
                prdata[7:0] = f0l_q;
            end else if (paddr == RFE_ADDR_F0_HIGH) begin
                prdata[7:0] = f0h_q;
            end else if (paddr == RFE_ADDR_F1_LOW) begin
                prdata[7:0] = f1l_q;
            end else if (paddr == RFE_ADDR_F1_HIGH) begin
                prdata[7:0] = f1h_q;
            end else if (paddr == RFE_ADDR_RF_CTRL) begin
                prdata[7:0] = rfc_q;
            end else if (paddr == RFE_ADDR_TX_CTRL) begin
                prdata[15:8] = len_q;
            end else if (paddr == RFE_ADDR_TX_STAT) begin
                prdata[2:0] = {lk2_q, st_q != RFE_ST_IDLE, alarm_q};
            end else begin
                pslverr = 1'b1;
            end
        end
    end

    assign ram_addr = ptr_q;
    assign ram_rd = (st_q == RFE_ST_FETCH);
    assign cpu_halt = (st_q != RFE_ST_IDLE);
    assign pll_en = (st_q != RFE_ST_IDLE);
    assign xtal_en = pll_en;
    assign xtal_26m_sel = rfc_q[RFE_XTAL_BIT];
    assign pll_n = rfc_q[RFE_BAND_BIT] ? RFE_N_HIGH : RFE_N_LOW;
    assign pll_frac = (fsk && ser_q) ? {f1h_q[4:0], f1l_q} : {f0h_q[4:0], f0l_q};
    assign sd_data = fsk ? ser_q : 1'b0;
    assign pa_en = enc_q && lk2_q && (fsk || ser_q);
    assign lock_alarm = alarm_q;
    assign gpio2_data = ser_q;
    assign gpio2_oe_n = !(rfc_q[RFE_PINEN_BIT] && enc_q);
endmodule

/* rtl/rfe_pkg.sv */
package rfe_pkg;
    // ---------------------------------------------
    // Register byte addresses
    // ---------------------------------------------
    localparam logic [7:0] RFE_ADDR_BAUD_CFG = 8'h00;
    localparam logic [7:0] RFE_ADDR_F0_LOW   = 8'h04;
    localparam logic [7:0] RFE_ADDR_F0_HIGH  = 8'h08;
    localparam logic [7:0] RFE_ADDR_F1_LOW   = 8'h0C;
    localparam logic [7:0] RFE_ADDR_F1_HIGH  = 8'h10;
    localparam logic [7:0] RFE_ADDR_RF_CTRL  = 8'h14;
    localparam logic [7:0] RFE_ADDR_TX_CTRL  = 8'h18;
    localparam logic [7:0] RFE_ADDR_TX_STAT  = 8'h1C;
    // ---------------------------------------------
    // Field positions
    // ---------------------------------------------
    localparam int RFE_BAUD_LSB      = 6;
    localparam int RFE_BAND_BIT      = 7;
    localparam int RFE_XTAL_BIT      = 0;
    localparam int RFE_FSK_BIT       = 1;
    localparam int RFE_PINEN_BIT     = 2;
    localparam int RFE_GO_BIT        = 0;
    localparam int RFE_FRAC_W        = 13;
    // ---------------------------------------------
    // Reset values and constants
    // ---------------------------------------------
    localparam logic [7:0] RFE_RST_REG   = 8'h00;
    localparam logic [7:0] RFE_N_LOW     = 8'h1A;
    localparam logic [7:0] RFE_N_HIGH    = 8'h24;
    localparam logic [7:0] RFE_RAM_BASE  = 8'h80;
    localparam logic [7:0] RFE_LEN_RST   = 8'h00;
    localparam int RFE_SETTLE_CYC        = 16;
    localparam logic [7:0] RFE_SETTLE_CNT = 8'(RFE_SETTLE_CYC);
    // Divider: half-symbol ticks; PWM counts thirds of a bit
    localparam logic [3:0] RFE_DIV_MS_00 = 4'h2;
    localparam logic [3:0] RFE_DIV_MS_01 = 4'h8;
    localparam logic [3:0] RFE_DIV_MS_10 = 4'h4;
    localparam logic [3:0] RFE_DIV_MS_11 = 4'h1;
    localparam logic [3:0] RFE_DIV_PW_00 = 4'h2;
    localparam logic [3:0] RFE_DIV_PW_01 = 4'h8;
    localparam logic [3:0] RFE_DIV_PW_10 = 4'h4;
    localparam logic [3:0] RFE_DIV_PW_11 = 4'h1;

    typedef enum logic [2:0] {
        RFE_FMT_MARKSPACE = 3'b001,
        RFE_FMT_MANCH     = 3'b000,
        RFE_FMT_PWM       = 3'b010,
        RFE_FMT_BIPH0     = 3'b100,
        RFE_FMT_BIPH1     = 3'b110,
        RFE_FMT_DBIPH0    = 3'b101,
        RFE_FMT_DBIPH1    = 3'b111
    } rfe_fmt_t;

    typedef enum logic [2:0] {
        RFE_ST_IDLE   = 3'b000,
        RFE_ST_SETTLE = 3'b001,
        RFE_ST_FETCH  = 3'b010,
        RFE_ST_LOAD   = 3'b011,
        RFE_ST_SHIFT  = 3'b100,
        RFE_ST_DONE   = 3'b101
    } rfe_state_t;
endpackage

/* verif/rfe_tx_asserts.sv */
`timescale 1ns/1ps
// ---------------------------
// Port checker
// ---------------------------
module rfe_tx_asserts
    import rfe_pkg::*;
(
    // Watched ports
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  ram_addr,
    input wire logic        ram_rd,
    input wire logic        pll_en,
    input wire logic        xtal_en,
    input wire logic [7:0]  pll_n,
    input wire logic [12:0] pll_frac,
    input wire logic        sd_data,
    input wire logic        pa_en,
    input wire logic        lock_alarm,
    input wire logic        cpu_halt,
    input wire logic        gpio2_data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ALARM_MUTE: assert property ($rose(lock_alarm) |-> ##[0:2] !pa_en)
        else $error("amplifier not muted on lock loss");
    AST_PA_POWER: assert property (pa_en |-> pll_en && xtal_en)
        else $error("amplifier on without pll");
    AST_FSK_PA: assert property (sd_data && !lock_alarm |-> (pa_en or (##[1:3] lock_alarm)))
        else $error("fsk data without amplifier");
    AST_IDLE_LOW: assert property (!cpu_halt [*3] |-> !pa_en && !gpio2_data)
        else $error("serial output active while idle");
    AST_END_OFF: assert property ($fell(cpu_halt) |-> !pll_en && !pa_en)
        else $error("power left on after transmission");
    AST_SETTLE: assert property ($rose(cpu_halt) |-> (pll_en && !ram_rd) [*8])
        else $error("fetch before pll settle");
    AST_FETCH_ONE: assert property (ram_rd |=> !ram_rd)
        else $error("fetch strobe longer than one cycle");
    AST_FETCH_BASE: assert property (ram_rd |-> ram_addr >= RFE_RAM_BASE)
        else $error("fetch below payload base");
    AST_BAND_N: assert property (pll_n == RFE_N_LOW || pll_n == RFE_N_HIGH)
        else $error("divider integer out of set");
    AST_FRAC_DATA: assert property (cpu_halt && $changed(pll_frac) |-> $changed(sd_data))
        else $error("frequency word moved without data");
endmodule

bind rfe_tx_encoder rfe_tx_asserts u_chk (.pclk, .presetn, .ram_addr, .ram_rd, .pll_en,
    .xtal_en, .pll_n, .pll_frac, .sd_data, .pa_en, .lock_alarm, .cpu_halt, .gpio2_data);

/* verif/rfe_pll_model.sv */
`timescale 1ns/1ps
// ---------------------------
// PLL lock model
// ---------------------------
module rfe_pll_model #(
    parameter int LOCK_DLY = 20
) (
    // Clock and control
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pll_en,
    input  wire logic lock_drop,
    // Lock status
    output logic      pll_lock
);
    int   cnt;
    logic lost;
    // settle then lock, drop on command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= 0;
            lost     <= 1'b0;
            pll_lock <= 1'b0;
        end else if (!pll_en) begin
            cnt      <= 0;
            lost     <= 1'b0;
            pll_lock <= 1'b0;
        end else begin
            cnt      <= (cnt < LOCK_DLY) ? cnt + 1 : cnt;
            lost     <= lost | lock_drop;
            pll_lock <= (cnt == LOCK_DLY) && !lost && !lock_drop;
        end
    end
endmodule

/* verif/rf_tx_encoder_controller_tb.sv */
`timescale 1ns/1ps
module rf_tx_encoder_controller_tb;
    import rfe_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [7:0]  paddr, ram_addr, ram_rdata, pll_n;
    logic [31:0] pwdata, prdata, rd;
    logic        ram_rd, pll_lock, pll_en, xtal_en, xtal_26m_sel, sd_data, pa_en;
    logic        lock_alarm, cpu_halt, gpio2_data, gpio2_oe_n, lock_drop, fsk, arm;
    logic [12:0] pll_frac, w0, w1;
    logic [7:0]  mem [256];
    int          error_cnt, checks, cyc, hw, wmin, wmax, nrd, nbad, npa, npin;
    int          bitclk [2][4] = '{'{4, 16, 8, 2}, '{6, 24, 12, 3}};

    rfe_tx_encoder uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ram_addr, .ram_rd, .ram_rdata, .pll_lock, .pll_en, .xtal_en,
        .xtal_26m_sel, .pll_n, .pll_frac, .sd_data, .pa_en, .lock_alarm, .cpu_halt,
        .gpio2_data, .gpio2_oe_n);
    rfe_pll_model u_pll (.pclk, .presetn, .pll_en, .lock_drop, .pll_lock);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // ---------------------------
    // Payload memory and monitors
    // ---------------------------
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (ram_rd === 1'b1) begin
            ram_rdata <= mem[ram_addr];
            nrd       <= nrd + 1;
        end
        if (arm && pa_en === 1'b1) lock_drop <= 1'b1;
        if (fsk && cpu_halt === 1'b1 && pll_frac !== (sd_data ? w1 : w0)) nbad <= nbad + 1;
        if (gpio2_oe_n === 1'b0 && gpio2_data === sd_data) npin <= npin + 1;
        if (pa_en === 1'b1) begin
            hw  <= hw + 1;
            npa <= npa + (hw == 0);
        end else if (hw != 0) begin
            wmin <= (hw < wmin) ? hw : wmin;
            wmax <= (hw > wmax) ? hw : wmax;
            hw   <= 0;
        end
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd   = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic run_tx(input logic [7:0] len);
        #1;
        nrd  = 0;
        wmin = 999;
        wmax = 0;
        npa  = 0;
        nbad = 0;
        npin = 0;
        @(posedge pclk);
        apb(1'b1, RFE_ADDR_TX_CTRL, {16'h0, len, 8'h01});
        check(cpu_halt, 1, "halt at start");
        while (cpu_halt === 1'b1) @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask

    task automatic t_regs();
        apb(1'b0, RFE_ADDR_BAUD_CFG, 0);
        check(rd, 32'(RFE_RST_REG), "reset value");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 8'(4 * i), 32'h5A + i);
            apb(1'b0, 8'(4 * i), 0);
            check(rd, 32'h5A + i, "readback");
        end
        check(pll_frac, 13'h1C5B, "ask word");
        apb(1'b1, RFE_ADDR_RF_CTRL, 32'h81);
        check({pll_n, xtal_26m_sel}, {8'd36, 1'b1}, "band high");
        apb(1'b1, RFE_ADDR_RF_CTRL, 32'h04);
        check({pll_n, xtal_26m_sel, gpio2_oe_n}, {8'd26, 2'b01}, "band low");
        apb(1'b0, 8'h40, 0);
        check(serr, 1, "unmapped read");
        $display("test regs done");
    endtask

    task automatic t_rates();
        mem[8'h80] = 8'h00;
        apb(1'b1, RFE_ADDR_RF_CTRL, 32'h00);
        for (int f = 0; f < 2; f++) begin
            for (int b = 0; b < 4; b++) begin
                apb(1'b1, RFE_ADDR_BAUD_CFG, {24'h0, 2'(b), 3'b0, f ? RFE_FMT_PWM : RFE_FMT_MANCH});
                run_tx(8'd1);
                check(wmin, bitclk[f][b] / (f ? 3 : 2), "shortest pulse");
                check(wmax, bitclk[f][b] / (f ? 3 : 2), "longest pulse");
                check(nrd, 1, "fetch count");
            end
        end
        $display("test rates done");
    endtask

    task automatic t_formats();
        rfe_fmt_t fm [7] = '{RFE_FMT_MARKSPACE, RFE_FMT_MANCH, RFE_FMT_PWM, RFE_FMT_BIPH0,
            RFE_FMT_BIPH1, RFE_FMT_DBIPH0, RFE_FMT_DBIPH1};
        mem[8'h80] = 8'hA5;
        mem[8'h81] = 8'h3C;
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, RFE_ADDR_BAUD_CFG, {29'h0, fm[i]});
            run_tx(8'd2);
            check(nrd, 2, "format fetches");
            check(npa != 0, 1, "format pulses");
        end
        $display("test formats done");
    endtask

    task automatic t_fsk();
        w0 = 13'h1234;
        w1 = 13'h0BCD;
        apb(1'b1, RFE_ADDR_F0_LOW, 32'h34);
        apb(1'b1, RFE_ADDR_F0_HIGH, 32'h12);
        apb(1'b1, RFE_ADDR_F1_LOW, 32'hCD);
        apb(1'b1, RFE_ADDR_F1_HIGH, 32'hAB);
        apb(1'b1, RFE_ADDR_RF_CTRL, 32'h06);
        apb(1'b1, RFE_ADDR_BAUD_CFG, 32'h0);
        fsk = 1'b1;
        run_tx(8'd1);
        check(nbad, 0, "fsk words");
        check(npa, 1, "fsk amplifier");
        check(npin, 35, "pin stream");
        $display("test fsk done");
    endtask

    task automatic t_lock();
        for (int i = 0; i < 4; i++) mem[8'h80 + i] = 8'hF0;
        arm = 1'b1;
        run_tx(8'd4);
        arm = 1'b0;
        lock_drop <= 1'b0;
        check({lock_alarm, pa_en, nrd < 4}, 3'b101, "lock loss");
        apb(1'b0, RFE_ADDR_TX_STAT, 0);
        check(rd[0], 1, "alarm status");
        apb(1'b1, RFE_ADDR_TX_STAT, 32'h1);
        apb(1'b0, RFE_ADDR_TX_STAT, 0);
        check(rd[0], 0, "alarm cleared");
        $display("test lock done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ram_rdata} = '0;
        {lock_drop, fsk, arm, error_cnt, checks, cyc, hw, nrd, npa, nbad} = '0;
        w0 = '0;
        w1 = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_rates();
        t_formats();
        t_fsk();
        t_lock();
        report_and_stop();
    end
endmodule
